/* hdl/byte_engine.sv */
`timescale 1ns/1ps
module byte_engine (
  input wire logic scl_clk,
  input wire logic link_rst_n,
  input wire logic sda_in,
  input wire logic [1:0] strap_address_bits,
  input wire logic [7:0] tx_byte,
  output logic pull_low,
  output logic byte_rdy,
  output logic byte_is_reg,
  output logic [7:0] byte_val
);

  typedef struct packed {
    led_i2c_pkg::link_state_e st;
    logic [3:0] slot;
    logic [7:0] sh;
    logic rd;
    logic low;
    logic rdy;
    logic isreg;
  } eng_s;

  eng_s s_q;
  eng_s s_d;
  logic [7:0] rx;
  logic match;

  always_comb begin
    s_d = s_q;
    rx = {s_q.sh[6:0], sda_in};
    match = (rx[7:3] == led_i2c_pkg::FIXED_ADDRESS_BITS) &&
            (rx[2:1] == strap_address_bits);
    if (s_q.slot != led_i2c_pkg::ACK_SLOT) begin
      s_d.slot = s_q.slot + 4'h1;
      if (s_q.st == led_i2c_pkg::st_read) begin
        // Next bit shown from the coming low phase on
        s_d.sh = {s_q.sh[6:0], 1'b1};
        if (s_q.slot == led_i2c_pkg::LAST_BIT_SLOT) begin
          s_d.low = 1'b0;
        end else begin
          s_d.low = ~s_q.sh[6];
        end
      end else if (s_q.st != led_i2c_pkg::st_ignore) begin
        s_d.sh = rx;
        if (s_q.slot == led_i2c_pkg::LAST_BIT_SLOT) begin
          case (s_q.st)
            led_i2c_pkg::st_addr: begin
              if (match) begin
                s_d.low = 1'b1;
                s_d.rd = rx[0];
              end else begin
                s_d.st = led_i2c_pkg::st_ignore;
              end
            end
            led_i2c_pkg::st_reg: begin
              s_d.low = 1'b1;
              s_d.rdy = 1'b1;
              s_d.isreg = 1'b1;
            end
            default: begin
              s_d.low = 1'b1;
              s_d.rdy = 1'b1;
              s_d.isreg = 1'b0;
            end
          endcase
        end
      end
    end else begin
      s_d.slot = led_i2c_pkg::SLOT_RST;
      s_d.rdy = 1'b0;
      s_d.low = 1'b0;
      case (s_q.st)
        led_i2c_pkg::st_addr: begin
          if (s_q.rd) begin
            s_d.st = led_i2c_pkg::st_read;
            s_d.sh = tx_byte;
            s_d.low = ~tx_byte[7];
          end else begin
            s_d.st = led_i2c_pkg::st_reg;
          end
        end
        led_i2c_pkg::st_reg: begin
          s_d.st = led_i2c_pkg::st_data;
        end
        led_i2c_pkg::st_read: begin
          // Controller ack repeats the same register; nack lets go
          if (!sda_in) begin
            s_d.sh = tx_byte;
            s_d.low = ~tx_byte[7];
          end else begin
            s_d.st = led_i2c_pkg::st_ignore;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Cleared on every start and stop by the system side
  always_ff @(posedge scl_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      s_q.st <= led_i2c_pkg::st_addr;
      s_q.slot <= led_i2c_pkg::SLOT_RST;
      s_q.sh <= led_i2c_pkg::BYTE_RST;
      s_q.rd <= 1'b0;
      s_q.low <= 1'b0;
      s_q.rdy <= 1'b0;
      s_q.isreg <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pull_low = s_q.low;
  assign byte_rdy = s_q.rdy;
  assign byte_is_reg = s_q.isreg;
  assign byte_val = s_q.sh;

endmodule

/* hdl/led_matrix_i2c_target_port.sv */
`timescale 1ns/1ps
module led_matrix_i2c_target_port (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic addr_sel,
  input wire logic [7:0] rd_data,
  output logic [7:0] rd_addr,
  output logic wr_valid,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic bus_busy,
  output logic [1:0] strap_address_bits
);

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic sel_m;
    logic sel_s;
    logic sel_p;
    logic arm_m;
    logic arm_s;
    logic low_m;
    logic low_s;
    logic rdy_m;
    logic rdy_s;
    logic rdy_p;
    logic [1:0] clr_cnt;
    logic clr;
    logic [3:0] miss;
    logic [1:0] strap;
    logic [7:0] ptr;
    logic [7:0] rd_hold;
    logic wr_valid;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic sda_oe;
    logic sda_o;
    logic busy;
  } port_s;

  port_s q_q;
  port_s q_d;

  logic eng_rst_n;
  logic pull_low;
  logic byte_rdy;
  logic byte_is_reg;
  logic [7:0] byte_val;

  logic start_seen;
  logic stop_seen;
  logic scl_fall;
  logic stable;
  logic [3:0] cand;

  // Engine is held idle while the clear pulse stands
  assign eng_rst_n = nrst & ~q_q.clr;

  byte_engine u_engine (
    .scl_clk(scl),
    .link_rst_n(eng_rst_n),
    .sda_in(sda_i),
    .strap_address_bits(q_q.strap),
    .tx_byte(q_q.rd_hold),
    .pull_low(pull_low),
    .byte_rdy(byte_rdy),
    .byte_is_reg(byte_is_reg),
    .byte_val(byte_val)
  );

  always_comb begin
    q_d = q_q;
    start_seen = q_q.scl_s & q_q.scl_p & q_q.sda_p & ~q_q.sda_s;
    stop_seen = q_q.scl_s & q_q.scl_p & ~q_q.sda_p & q_q.sda_s;
    scl_fall = q_q.scl_p & ~q_q.scl_s;
    // Reset levels in the chains are not pin levels; wait until flushed
    stable = q_q.arm_s && (q_q.scl_s == q_q.scl_p) &&
             (q_q.sda_s == q_q.sda_p) && (q_q.sel_s == q_q.sel_p);
    cand = {1'b1, q_q.sda_s, q_q.scl_s, 1'b0};

    // Pins and engine levels, two flops before use
    q_d.scl_m = scl;
    q_d.scl_s = q_q.scl_m;
    q_d.scl_p = q_q.scl_s;
    q_d.sda_m = sda_i;
    q_d.sda_s = q_q.sda_m;
    q_d.sda_p = q_q.sda_s;
    q_d.sel_m = addr_sel;
    q_d.sel_s = q_q.sel_m;
    q_d.sel_p = q_q.sel_s;
    q_d.arm_m = 1'b1;
    q_d.arm_s = q_q.arm_m;
    q_d.low_m = pull_low;
    q_d.low_s = q_q.low_m;
    q_d.rdy_m = byte_rdy;
    q_d.rdy_s = q_q.rdy_m;
    q_d.rdy_p = q_q.rdy_s;

    // Read data follows the pointer; engine samples it at the ack edge
    q_d.rd_hold = rd_data;
    q_d.wr_valid = 1'b0;
    q_d.sda_o = 1'b0;

    // Start or stop restarts the engine and drops any drive
    if (start_seen || stop_seen) begin
      q_d.clr_cnt = led_i2c_pkg::CLEAR_CYCLES;
      q_d.sda_oe = 1'b0;
      q_d.busy = start_seen;
    end else begin
      if (q_q.clr_cnt != led_i2c_pkg::CLEAR_IDLE) begin
        q_d.clr_cnt = q_q.clr_cnt - 2'h1;
      end
      // Drive changes only while the clock is low
      if (scl_fall) begin
        q_d.sda_oe = q_q.low_s & q_q.busy;
      end
    end
    q_d.clr = (q_d.clr_cnt != led_i2c_pkg::CLEAR_IDLE);

    // Byte handed over while the engine holds it for the ack slot
    if (q_q.rdy_s && !q_q.rdy_p) begin
      if (byte_is_reg) begin
        q_d.ptr = byte_val;
      end else begin
        q_d.wr_valid = 1'b1;
        q_d.wr_addr = q_q.ptr;
        q_d.wr_data = byte_val;
        q_d.ptr = q_q.ptr + 8'h01;
      end
    end

    // Strap wiring found by watching which level the pin follows
    for (int i = 0; i < 4; i++) begin
      if (stable && (q_q.sel_s != cand[i])) begin
        q_d.miss[i] = 1'b1;
      end
    end
    if (!q_q.miss[led_i2c_pkg::STRAP_GND]) begin
      q_d.strap = led_i2c_pkg::STRAP_GND;
    end else if (!q_q.miss[led_i2c_pkg::STRAP_VCC]) begin
      q_d.strap = led_i2c_pkg::STRAP_VCC;
    end else if (!q_q.miss[led_i2c_pkg::STRAP_SCL]) begin
      q_d.strap = led_i2c_pkg::STRAP_SCL;
    end else if (!q_q.miss[led_i2c_pkg::STRAP_SDA]) begin
      q_d.strap = led_i2c_pkg::STRAP_SDA;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q_q.scl_m <= 1'b1;
      q_q.scl_s <= 1'b1;
      q_q.scl_p <= 1'b1;
      q_q.sda_m <= 1'b1;
      q_q.sda_s <= 1'b1;
      q_q.sda_p <= 1'b1;
      q_q.sel_m <= 1'b0;
      q_q.sel_s <= 1'b0;
      q_q.sel_p <= 1'b0;
      q_q.arm_m <= 1'b0;
      q_q.arm_s <= 1'b0;
      q_q.low_m <= 1'b0;
      q_q.low_s <= 1'b0;
      q_q.rdy_m <= 1'b0;
      q_q.rdy_s <= 1'b0;
      q_q.rdy_p <= 1'b0;
      q_q.clr_cnt <= led_i2c_pkg::CLEAR_IDLE;
      q_q.clr <= 1'b0;
      q_q.miss <= led_i2c_pkg::MISS_RST;
      q_q.strap <= led_i2c_pkg::STRAP_RST;
      q_q.ptr <= led_i2c_pkg::POINTER_RST;
      q_q.rd_hold <= led_i2c_pkg::BYTE_RST;
      q_q.wr_valid <= 1'b0;
      q_q.wr_addr <= led_i2c_pkg::BYTE_RST;
      q_q.wr_data <= led_i2c_pkg::BYTE_RST;
      q_q.sda_oe <= 1'b0;
      q_q.sda_o <= 1'b0;
      q_q.busy <= 1'b0;
    end else begin
      q_q <= q_d;
    end
  end

  assign sda_o = q_q.sda_o;
  assign sda_oe = q_q.sda_oe;
  assign rd_addr = q_q.ptr;
  assign wr_valid = q_q.wr_valid;
  assign wr_addr = q_q.wr_addr;
  assign wr_data = q_q.wr_data;
  assign bus_busy = q_q.busy;
  assign strap_address_bits = q_q.strap;

endmodule

/* include/led_i2c_pkg.sv */
// Notes on behaviour
// - Answer 7-bit target address, low bit direction
// - Direction bit 0 writes, 1 reads
// - Upper five address bits fixed at 01101
// - Strap pin wiring picks low address bits
// - Serial data sampled while clock stays high
// - Data falling while clock high is start
// - Join transfer only on address match
// - Hold data low through address acknowledge
// - Register address byte follows and is acknowledged
// - Acknowledge every received data byte
// - Data rising while clock high is stop
// - Pointer advances by one per data byte (written bytes only; reads do not step it)
// - Read returns register chosen by pointer
package led_i2c_pkg;

  localparam logic [4:0] FIXED_ADDRESS_BITS = 5'h0d;

  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_SCL = 2'h1;
  localparam logic [1:0] STRAP_SDA = 2'h2;
  localparam logic [1:0] STRAP_VCC = 2'h3;

  localparam logic [3:0] LAST_BIT_SLOT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] SLOT_RST = 4'h0;

  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] POINTER_RST = 8'h00;
  localparam logic [1:0] STRAP_RST = STRAP_GND;
  localparam logic [3:0] MISS_RST = 4'h0;

  // Clear width must stay well inside the start hold time
  localparam logic [1:0] CLEAR_CYCLES = 2'h2;
  localparam logic [1:0] CLEAR_IDLE = 2'h0;

  typedef enum logic [2:0] {
    st_addr,
    st_reg,
    st_data,
    st_read,
    st_ignore
  } link_state_e;

endpackage

/* verification/i2c_ctrl_model.sv */
`timescale 1ns/1ps
module i2c_ctrl_model (
  output logic scl,
  output logic hold_low,
  input wire logic sda
);
  logic tk = 1'b0;
  initial begin
    scl = 1'b1;
    hold_low = 1'b0;
  end
  // 12 ns tick, phase unrelated to clk
  initial #3 forever #6 tk = ~tk;
  task automatic wt(input int n);
    repeat (n) @(posedge tk);
  endtask
  task automatic bit_io(input logic b, output logic s);
    wt(20);
    hold_low = !b;
    wt(22);
    scl = 1'b1;
    wt(22);
    s = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    wt(20);
    hold_low = 1'b0;
    wt(10);
    scl = 1'b1;
    wt(22);
    hold_low = 1'b1;
    wt(22);
    scl = 1'b0;
  endtask
  task automatic stop();
    wt(20);
    hold_low = 1'b1;
    wt(10);
    scl = 1'b1;
    wt(22);
    hold_low = 1'b0;
    wt(22);
  endtask
  task automatic send(input logic [7:0] b, output logic [7:0] ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = {7'h00, !s};
  endtask
  task automatic recv(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(1'b1, s);
  endtask
endmodule

/* verification/led_matrix_i2c_target_port_tb.sv */
`timescale 1ns/1ps
module led_matrix_i2c_target_port_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic [1:0] mode = 2'h0;
  int n_fail = 0;
  int n_tests = 0;
  logic [16:0] rnd = 17'h1106b;
  logic [7:0] wq[$];
  logic scl, hold_low, sda_o, sda_oe, wr_valid, bus_busy;
  logic [7:0] rd_addr, wr_addr, wr_data;
  logic [1:0] strap;
  // Open drain with pull-up: released means high
  wire sda = !(hold_low || sda_oe);
  wire addr_sel = mode == 2'h0 ? 1'b0 : mode == 2'h1 ? scl :
    mode == 2'h2 ? sda : 1'b1;
  led_matrix_i2c_target_port dut (.clk, .nrst, .scl, .sda_i(sda), .sda_o,
    .sda_oe, .addr_sel, .rd_data, .rd_addr, .wr_valid, .wr_addr, .wr_data,
    .bus_busy, .strap_address_bits(strap));
  i2c_ctrl_model u_ctl (.scl, .hold_low, .sda);
  always #12.5 clk = ~clk;
  always @(negedge clk) rd_data <= rd_addr ^ 8'h5a;
  function automatic logic [16:0] lfsr(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(negedge clk) begin
    if (wr_valid === 1'b1) begin
      chk(wr_addr, wq.pop_front());
      chk(wr_data, wq.pop_front());
    end
  end
  initial begin
    #2000000;
    n_fail++;
    complete_run();
  end
  initial begin
    logic [7:0] a, r, d, q;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk) nrst = 1'b0;
      mode = k[1:0];
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      rnd = lfsr(rnd);
      r = rnd[7:0];
      u_ctl.start();
      u_ctl.send({5'h0d, k[1:0], 1'b0}, a);
      chk(a, 8'h01);
      chk({6'h00, strap}, {6'h00, k[1:0]});
      chk({7'h00, bus_busy}, 8'h01);
      u_ctl.send(r, a);
      chk(a, 8'h01);
      for (int j = 0; j < 2; j++) begin
        rnd = lfsr(rnd);
        d = rnd[7:0];
        wq.push_back(r + 8'(j));
        wq.push_back(d);
        u_ctl.send(d, a);
        chk(a, 8'h01);
      end
      u_ctl.stop();
      chk({7'h00, bus_busy}, 8'h00);
      chk(rd_addr, r + 8'h02);
      u_ctl.start();
      u_ctl.send({5'h0d, ~k[1:0], 1'b0}, a);
      chk(a, 8'h00);
      u_ctl.send(d, a);
      chk(a, 8'h00);
      u_ctl.stop();
      rnd = lfsr(rnd);
      r = rnd[15:8];
      u_ctl.start();
      u_ctl.send({5'h0d, k[1:0], 1'b0}, a);
      u_ctl.send(r, a);
      u_ctl.start();
      u_ctl.send({5'h0d, k[1:0], 1'b1}, a);
      chk(a, 8'h01);
      u_ctl.recv(q);
      chk(q, r ^ 8'h5a);
      u_ctl.stop();
      $display("strap case %0d done", k);
    end
    chk(8'(wq.size()), 8'h00);
    complete_run();
  end
endmodule

/* verification/led_port_chk.sv */
`timescale 1ns/1ps
module led_port_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [7:0] rd_addr,
  input wire logic wr_valid,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic bus_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_held;
    sda_oe [*8];
  endsequence
  property p_od; sda_oe |-> !sda_o; endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  property p_hold; $rose(sda_oe) |=> s_held; endproperty
  a_hold: assert property (p_hold) else $error("ack cut short");
  property p_oeb; sda_oe |-> bus_busy; endproperty
  a_oeb: assert property (p_oeb) else $error("drive off bus");
  property p_pulse; wr_valid |=> !wr_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("long write");
  property p_ptr; wr_valid |-> ##[0:1] rd_addr == wr_addr + 8'h01; endproperty
  a_ptr: assert property (p_ptr) else $error("pointer step");
  property p_stab;
    !wr_valid |-> $stable(wr_addr) && $stable(wr_data);
  endproperty
  a_stab: assert property (p_stab) else $error("write moved");
  property p_start; $fell(sda_i) && scl |-> ##[1:6] bus_busy; endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_stop; $rose(sda_i) && scl |-> ##[1:6] !bus_busy; endproperty
  a_stop: assert property (p_stop) else $error("stop missed");
endmodule
bind led_matrix_i2c_target_port led_port_chk u_chk (.clk, .nrst, .scl,
  .sda_i, .sda_o, .sda_oe, .rd_addr, .wr_valid, .wr_addr, .wr_data,
  .bus_busy);
